// ===== common/asdr_pkg.sv
// Purpose: Shared constants and types for the stream descriptor ring block
// Assumes: Eight streams, input streams 0-3 first, output streams 0-3 next
// Notes:   Offsets are byte offsets from the controller memory base
package asdr_pkg;

   localparam int unsigned ASDR_STREAMS    = 8;
   localparam int unsigned ASDR_IN_STREAMS = 4;
   localparam int unsigned ASDR_AW         = 9;
   localparam int unsigned ASDR_DW         = 16;
   localparam int unsigned ASDR_IW         = 8;
   localparam int unsigned ASDR_FW         = 16;

   // Register map, one block of registers per stream
   localparam logic [8:0] ASDR_IN0_LAST_DESCRIPTOR_INDEX_OFS  = 9'h08C;
   localparam logic [8:0] ASDR_IN0_FIFO_DEPTH_OFS             = 9'h090;
   localparam logic [8:0] ASDR_IN1_LAST_DESCRIPTOR_INDEX_OFS  = 9'h0AC;
   localparam logic [8:0] ASDR_IN1_FIFO_DEPTH_OFS             = 9'h0B0;
   localparam logic [8:0] ASDR_IN2_LAST_DESCRIPTOR_INDEX_OFS  = 9'h0CC;
   localparam logic [8:0] ASDR_IN2_FIFO_DEPTH_OFS             = 9'h0D0;
   localparam logic [8:0] ASDR_IN3_LAST_DESCRIPTOR_INDEX_OFS  = 9'h0EC;
   localparam logic [8:0] ASDR_IN3_FIFO_DEPTH_OFS             = 9'h0F0;
   localparam logic [8:0] ASDR_OUT0_LAST_DESCRIPTOR_INDEX_OFS = 9'h10C;
   localparam logic [8:0] ASDR_OUT0_FIFO_DEPTH_OFS            = 9'h110;
   localparam logic [8:0] ASDR_OUT1_LAST_DESCRIPTOR_INDEX_OFS = 9'h12C;
   localparam logic [8:0] ASDR_OUT1_FIFO_DEPTH_OFS            = 9'h130;
   localparam logic [8:0] ASDR_OUT2_LAST_DESCRIPTOR_INDEX_OFS = 9'h14C;
   localparam logic [8:0] ASDR_OUT2_FIFO_DEPTH_OFS            = 9'h150;
   localparam logic [8:0] ASDR_OUT3_LAST_DESCRIPTOR_INDEX_OFS = 9'h16C;
   localparam logic [8:0] ASDR_OUT3_FIFO_DEPTH_OFS            = 9'h170;

   localparam logic [8:0] ASDR_STREAM0_BASE = ASDR_IN0_LAST_DESCRIPTOR_INDEX_OFS;
   localparam logic [8:0] ASDR_STREAM_SPAN  = 9'h100;
   localparam logic [4:0] ASDR_LDI_REL      = 5'h00;
   localparam logic [4:0] ASDR_DEPTH_REL    = 5'h04;

   // Reset values
   localparam logic [7:0]  ASDR_LDI_RESET   = 8'h00;
   localparam logic [7:0]  ASDR_IDX_RESET   = 8'h00;
   localparam logic [15:0] ASDR_RDATA_RESET = 16'h0000;

   // Format field positions
   localparam int unsigned ASDR_FMT_CHAN_LSB = 0;
   localparam int unsigned ASDR_FMT_BITS_LSB = 4;

   // Sample size codes
   localparam logic [2:0] ASDR_BITS_8  = 3'h0;
   localparam logic [2:0] ASDR_BITS_16 = 3'h1;

   // FIFO depths in dwords
   localparam logic [15:0] ASDR_DEPTH_IN   = 16'h0040;
   localparam logic [15:0] ASDR_DEPTH_MIN  = 16'h0020;
   localparam logic [15:0] ASDR_DEPTH_MAX  = 16'h0100;
   localparam logic [15:0] ASDR_DEPTH_UNIT = 16'h0020;

   typedef enum logic [1:0] {
      ASDR_KIND_NONE,
      ASDR_KIND_LDI,
      ASDR_KIND_DEPTH
   } asdr_kind_t;

   typedef struct packed {
      asdr_kind_t kind;
      logic [2:0] stream;
   } asdr_decode_t;

   typedef enum logic {
      ASDR_WALK_IDLE,
      ASDR_WALK_ACTIVE
   } asdr_walk_state_t;

endpackage

// ===== verilog/asdr_ring_walker.sv
// Purpose: Descriptor index walker for one stream
// Assumes: Completion pulses come from the fetch engine in the same clock
// Notes:   Index restarts at zero on every start of the stream
`timescale 1ns/100ps
`default_nettype none
module asdr_ring_walker
   import asdr_pkg::*;
(
   input  wire logic              clock_i,
   input  wire logic              nrst_i,
   input  wire logic              run_i,
   input  wire logic              desc_done_i,
   input  wire logic [ASDR_IW-1:0] last_index_i,
   output logic      [ASDR_IW-1:0] desc_index_o,
   output logic                    wrap_o,
   output logic                    active_o
);

   typedef struct packed {
      asdr_walk_state_t  state;
      logic [ASDR_IW-1:0] index;
      logic              wrap;
   } asdr_walk_t;

   asdr_walk_t walk_reg;
   asdr_walk_t walk_next;

   always_comb begin
      walk_next      = walk_reg;
      walk_next.wrap = 1'b0;
      unique case (walk_reg.state)
         ASDR_WALK_IDLE: begin
            if (run_i) begin
               walk_next.state = ASDR_WALK_ACTIVE;
               walk_next.index = ASDR_IDX_RESET;
            end
         end
         ASDR_WALK_ACTIVE: begin
            if (!run_i) begin
               walk_next.state = ASDR_WALK_IDLE;
            end else if (desc_done_i) begin
               if (walk_reg.index == last_index_i) begin
                  // Stays active: the ring never stops at its end
                  walk_next.index = ASDR_IDX_RESET;
                  walk_next.wrap  = 1'b1;
               end else begin
                  walk_next.index = ASDR_IW'(walk_reg.index + 8'h01);
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         walk_reg.state <= ASDR_WALK_IDLE;
         walk_reg.index <= ASDR_IDX_RESET;
         walk_reg.wrap  <= 1'b0;
      end else begin
         walk_reg <= walk_next;
      end
   end

   assign desc_index_o = walk_reg.index;
   assign wrap_o       = walk_reg.wrap;
   assign active_o     = (walk_reg.state == ASDR_WALK_ACTIVE);

endmodule
`default_nettype wire

// ===== verilog/asdr_descriptor_ring.sv
// Purpose: Per-stream last descriptor index and FIFO depth registers with ring walkers
// Assumes: Register strobes are one cycle wide and synchronous to clock_i
// Notes:   Read data returns one cycle after the read strobe
//
// Contract
// - After the last indexed descriptor the walker returns to zero and keeps running.
// - Each stream has a read-only 16-bit FIFO depth register in dwords.
// - Output stream depth lies within 32 to 256 dwords, chosen from format.
// - Input stream depth is always 64 dwords whatever the format.
// - Four input and four output stream blocks, 0x20 apart, at 0x8C and 0x10C.
`timescale 1ns/100ps
`default_nettype none
module asdr_descriptor_ring
   import asdr_pkg::*;
(
   input  wire logic                           clock_i,
   input  wire logic                           nrst_i,
   input  wire logic [ASDR_AW-1:0]             reg_addr_i,
   input  wire logic                           reg_wr_i,
   input  wire logic                           reg_rd_i,
   input  wire logic [1:0]                     reg_be_i,
   input  wire logic [ASDR_DW-1:0]             reg_wdata_i,
   output logic      [ASDR_DW-1:0]             reg_rdata_o,
   output logic                                reg_rvalid_o,
   input  wire logic [ASDR_STREAMS-1:0]        run_i,
   input  wire logic [ASDR_STREAMS*ASDR_FW-1:0] fmt_i,
   input  wire logic [ASDR_STREAMS-1:0]        desc_done_i,
   output logic      [ASDR_STREAMS*ASDR_IW-1:0] desc_index_o,
   output logic      [ASDR_STREAMS-1:0]        wrap_o,
   output logic      [ASDR_STREAMS-1:0]        active_o
);

   typedef struct packed {
      logic [ASDR_STREAMS-1:0][ASDR_IW-1:0] ldi;
      logic [ASDR_DW-1:0]                   rdata;
      logic                                 rvalid;
   } asdr_regs_t;

   asdr_regs_t regs_reg;
   asdr_regs_t regs_next;

   asdr_decode_t wr_dec;
   asdr_decode_t rd_dec;
   logic [ASDR_STREAMS-1:0][ASDR_DW-1:0] depth;

   // Stream blocks repeat every 0x20 bytes; the output blocks follow the input ones
   function automatic asdr_decode_t asdr_decode(input logic [ASDR_AW-1:0] addr);
      asdr_decode_t d;
      logic [ASDR_AW-1:0] rel;
      d.kind   = ASDR_KIND_NONE;
      d.stream = 3'h0;
      rel      = ASDR_AW'(addr - ASDR_STREAM0_BASE);
      if (addr >= ASDR_STREAM0_BASE && rel < ASDR_STREAM_SPAN) begin
         d.stream = rel[7:5];
         if (rel[4:0] == ASDR_LDI_REL) begin
            d.kind = ASDR_KIND_LDI;
         end else if (rel[4:0] == ASDR_DEPTH_REL) begin
            d.kind = ASDR_KIND_DEPTH;
         end
      end
      return d;
   endfunction

   // Depth grows with frame size so that wide formats get more buffering
   function automatic logic [ASDR_DW-1:0] asdr_out_depth(input logic [ASDR_FW-1:0] fmt);
      logic [2:0] bits;
      logic [4:0] chans;
      logic [6:0] frame_bytes;
      logic [4:0] frame_dw;
      logic [15:0] d;
      bits  = fmt[ASDR_FMT_BITS_LSB +: 3];
      chans = 5'(fmt[ASDR_FMT_CHAN_LSB +: 4]) + 5'h01;
      if (bits == ASDR_BITS_8) begin
         frame_bytes = 7'(chans);
      end else if (bits == ASDR_BITS_16) begin
         frame_bytes = 7'({chans, 1'b0});
      end else begin
         // 20, 24, 32 bit and reserved sizes all take a full dword container
         frame_bytes = 7'({chans, 2'b00});
      end
      frame_dw = 5'(({1'b0, frame_bytes} + 8'h03) >> 2);
      d = 16'(frame_dw) * ASDR_DEPTH_UNIT;
      if (d < ASDR_DEPTH_MIN) begin
         d = ASDR_DEPTH_MIN;
      end else if (d > ASDR_DEPTH_MAX) begin
         d = ASDR_DEPTH_MAX;
      end
      return d;
   endfunction

   assign wr_dec = asdr_decode(reg_addr_i);
   assign rd_dec = asdr_decode(reg_addr_i);

   genvar s;
   generate
      for (s = 0; s < ASDR_STREAMS; s++) begin : g_stream
         if (s < ASDR_IN_STREAMS) begin : g_in
            assign depth[s] = ASDR_DEPTH_IN;
         end else begin : g_out
            assign depth[s] = asdr_out_depth(fmt_i[s*ASDR_FW +: ASDR_FW]);
         end

         asdr_ring_walker u_walker (
            .clock_i      (clock_i),
            .nrst_i       (nrst_i),
            .run_i        (run_i[s]),
            .desc_done_i  (desc_done_i[s]),
            .last_index_i (regs_reg.ldi[s]),
            .desc_index_o (desc_index_o[s*ASDR_IW +: ASDR_IW]),
            .wrap_o       (wrap_o[s]),
            .active_o     (active_o[s])
         );
      end
   endgenerate

   always_comb begin
      regs_next        = regs_reg;
      regs_next.rvalid = 1'b0;
      // Upper byte is reserved and not stored; FIFO depth ignores writes
      if (reg_wr_i && wr_dec.kind == ASDR_KIND_LDI && reg_be_i[0]) begin
         regs_next.ldi[wr_dec.stream] = reg_wdata_i[ASDR_IW-1:0];
      end
      if (reg_rd_i) begin
         regs_next.rvalid = 1'b1;
         unique case (rd_dec.kind)
            ASDR_KIND_LDI: begin
               regs_next.rdata = {8'h00, regs_reg.ldi[rd_dec.stream]};
            end
            ASDR_KIND_DEPTH: begin
               regs_next.rdata = depth[rd_dec.stream];
            end
            ASDR_KIND_NONE: begin
               regs_next.rdata = ASDR_RDATA_RESET;
            end
            default: begin
               regs_next.rdata = ASDR_RDATA_RESET;
            end
         endcase
      end
   end

   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i) begin
         for (int i = 0; i < ASDR_STREAMS; i++) begin
            regs_reg.ldi[i] <= ASDR_LDI_RESET;
         end
         regs_reg.rdata  <= ASDR_RDATA_RESET;
         regs_reg.rvalid <= 1'b0;
      end else begin
         regs_reg <= regs_next;
      end
   end

   assign reg_rdata_o  = regs_reg.rdata;
   assign reg_rvalid_o = regs_reg.rvalid;

endmodule
`default_nettype wire

// ===== dv/asdr_host_model.sv
// Purpose: Host side model that completes buffer descriptors
// Assumes: Random bits from the bench decide when memory answers
// Notes:   Completes a descriptor only for a stream that was active and running the cycle before
`timescale 1ns/100ps
`default_nettype none
module asdr_host_model
   import asdr_pkg::*;
(
   input  wire logic                    clock_i,
   input  wire logic                    nrst_i,
   input  wire logic [ASDR_STREAMS-1:0] active_i,
   input  wire logic [ASDR_STREAMS-1:0] run_i,
   input  wire logic [ASDR_STREAMS-1:0] rnd_i,
   output logic      [ASDR_STREAMS-1:0] desc_done_o
);
   // Random stalls give both prompt and slow completions
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i)
         desc_done_o <= '0;
      else
         desc_done_o <= active_i & run_i & rnd_i;
   end
endmodule
`default_nettype wire

// ===== dv/asdr_ring_monitor.sv
// Purpose: Port assertions for the descriptor ring block
// Assumes: Stream 0 stands for every walker
// Notes:   Keeps its own copy of the stream 0 last index
`timescale 1ns/100ps
`default_nettype none
module asdr_ring_monitor
   import asdr_pkg::*;
(
   input wire logic                            clock_i,
   input wire logic                            nrst_i,
   input wire logic [ASDR_AW-1:0]              reg_addr_i,
   input wire logic                            reg_wr_i,
   input wire logic                            reg_rd_i,
   input wire logic [1:0]                      reg_be_i,
   input wire logic [ASDR_DW-1:0]              reg_wdata_i,
   input wire logic [ASDR_DW-1:0]              reg_rdata_o,
   input wire logic                            reg_rvalid_o,
   input wire logic [ASDR_STREAMS-1:0]         run_i,
   input wire logic [ASDR_STREAMS-1:0]         desc_done_i,
   input wire logic [ASDR_STREAMS*ASDR_IW-1:0] desc_index_o,
   input wire logic [ASDR_STREAMS-1:0]         wrap_o,
   input wire logic [ASDR_STREAMS-1:0]         active_o
);
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!nrst_i);
   logic [7:0] ldi0_reg;
   wire logic [7:0] idx0 = desc_index_o[7:0];
   wire logic go0 = active_o[0] && run_i[0] && desc_done_i[0];
   wire logic dep_rd = reg_rd_i && reg_addr_i[4:0] == 5'h10;
   always_ff @(posedge clock_i or negedge nrst_i) begin
      if (!nrst_i)
         ldi0_reg <= 8'h00;
      else if (reg_wr_i && reg_be_i[0] && reg_addr_i == 9'h08C)
         ldi0_reg <= reg_wdata_i[7:0];
   end
   sequence done_at_last;
      go0 && idx0 == ldi0_reg;
   endsequence
   sequence wrap_pulse;
      idx0 == 8'h00 && wrap_o[0] ##1 !wrap_o[0];
   endsequence
   read_answer_a: assert property (reg_rd_i |=> reg_rvalid_o)
      else $error("read not answered");
   no_stray_a: assert property (!reg_rd_i |=> !reg_rvalid_o)
      else $error("stray read valid");
   ldi_read_a: assert property (reg_rd_i && !reg_wr_i && reg_addr_i == 9'h08C
      |=> reg_rdata_o == {8'h00, ldi0_reg}) else $error("index read wrong");
   in_depth_a: assert property (dep_rd && reg_addr_i[8:7] == 2'b01
      |=> reg_rdata_o == 16'h0040) else $error("input depth wrong");
   out_depth_a: assert property (dep_rd && reg_addr_i[8:7] == 2'b10
      |=> reg_rdata_o inside {[16'h0020:16'h0100]} && reg_rdata_o[4:0] == 5'h00)
      else $error("output depth wrong");
   unmapped_a: assert property (reg_rd_i && reg_addr_i == 9'h088 |=> reg_rdata_o == 16'h0000)
      else $error("unmapped read not zero");
   start_zero_a: assert property (!active_o[0] && run_i[0] |=> active_o[0] && idx0 == 8'h00)
      else $error("start not at zero");
   step_one_a: assert property (go0 && idx0 != ldi0_reg
      |=> idx0 == $past(idx0) + 8'h01 && !wrap_o[0]) else $error("step wrong");
   wrap_back_a: assert property (done_at_last |=> wrap_pulse)
      else $error("wrap wrong");
   index_hold_a: assert property (active_o[0] && !desc_done_i[0] |=> $stable(idx0))
      else $error("index moved");
endmodule
bind asdr_descriptor_ring asdr_ring_monitor asdr_ring_monitor_inst (.clock_i, .nrst_i,
   .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_be_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o,
   .run_i, .desc_done_i, .desc_index_o, .wrap_o, .active_o);
`default_nettype wire

// ===== dv/test_asdr_descriptor_ring.sv
// Purpose: Self-checking bench for the descriptor ring block
// Assumes: Host model completes descriptors at random
// Notes:   Walker model steps on the same edges as the design
`timescale 1ns/100ps
`default_nettype none
module test_asdr_descriptor_ring import asdr_pkg::*;;
   logic          clock_i;
   logic          nrst_i       = 1'b0;
   logic          reg_wr_i     = 1'b0;
   logic          reg_rd_i     = 1'b0;
   logic [8:0]    reg_addr_i   = 9'h000;
   logic [1:0]    reg_be_i     = 2'h0;
   logic [15:0]   reg_wdata_i  = 16'h0000;
   logic [15:0]   reg_rdata_o;
   logic          reg_rvalid_o;
   logic [7:0]    run_i        = 8'h00;
   logic [7:0]    rnd          = 8'h00;
   logic [127:0]  fmt_i        = '0;
   logic [7:0]    desc_done_i, wrap_o, active_o;
   logic [63:0]   desc_index_o;
   logic [31:0]   lfsr         = 32'hE71C;
   int            bad_count, total_checks, ldi[8], idx[8], act[8], wrp[8];
   asdr_descriptor_ring asdr_descriptor_ring_inst (.clock_i, .nrst_i, .reg_addr_i, .reg_wr_i,
      .reg_rd_i, .reg_be_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .run_i, .fmt_i,
      .desc_done_i, .desc_index_o, .wrap_o, .active_o);
   asdr_host_model asdr_host_model_inst (.clock_i, .nrst_i, .active_i(active_o), .run_i,
      .rnd_i(rnd), .desc_done_o(desc_done_i));
   function automatic logic [31:0] step(logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic int depth(int s);
      int by;
      by = (fmt_i[16*s +: 4] + 1) * (fmt_i[16*s+4 +: 3] == 0 ? 1 : fmt_i[16*s+4 +: 3] == 1 ? 2 : 4);
      if (s < 4)
         return 64;
      return by > 32 ? 256 : (by + 3) / 4 * 32;
   endfunction
   task automatic check(string what, logic [15:0] exp, logic [15:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask
   task automatic tick;
      @(posedge clock_i);
      #2;
   endtask
   // Strobes drop one cycle before the next request so no edge sees two assignments
   task automatic wr(logic [8:0] a, logic [1:0] be, logic [15:0] d);
      reg_addr_i = a;
      reg_be_i = be;
      reg_wdata_i = d;
      reg_wr_i = 1'b1;
      tick;
      reg_wr_i = 1'b0;
      tick;
   endtask
   task automatic rd(logic [8:0] a, logic [15:0] exp);
      reg_addr_i = a;
      reg_rd_i = 1'b1;
      tick;
      reg_rd_i = 1'b0;
      check("read data", exp, reg_rdata_o);
      check("read valid", 16'h0001, 16'(reg_rvalid_o));
      tick;
      check("valid drop", 16'h0000, 16'(reg_rvalid_o));
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   initial begin
      clock_i = 1'b0;
      forever #25 clock_i = ~clock_i;
   end
   always @(posedge clock_i) begin
      #2;
      lfsr = step(lfsr);
      rnd = lfsr[7:0];
   end
   always @(posedge clock_i) begin
      for (int s = 0; s < 8; s++) begin
         wrp[s] = 0;
         if (!nrst_i) begin
            act[s] = 0;
            idx[s] = 0;
         end else if (!act[s]) begin
            act[s] = run_i[s];
            idx[s] = run_i[s] ? 0 : idx[s];
         end else if (!run_i[s])
            act[s] = 0;
         else if (desc_done_i[s]) begin
            wrp[s] = idx[s] == ldi[s];
            idx[s] = wrp[s] ? 0 : idx[s] + 1;
         end
      end
   end
   always @(negedge clock_i) begin
      for (int s = 0; s < 8; s++) begin
         if (nrst_i) begin
            check("index", idx[s], desc_index_o[8*s +: 8]);
            check("wrap", wrp[s], wrap_o[s]);
            check("active", act[s], active_o[s]);
         end
      end
   end
   initial begin
      #250000;
      bad_count++;
      give_verdict;
   end
   initial begin
      repeat (12) tick;
      nrst_i = 1'b1;
      rd(9'h088, 16'h0000);
      wr(9'h110, 2'b11, 16'hFFFF);
      for (int z = 0; z < 8; z++) begin
         fmt_i = {8{lfsr[15:7], 3'(z), lfsr[3:0]}};
         for (int s = 0; s < 8; s++)
            rd(9'h090 + 9'(32 * s), 16'(depth(s)));
      end
      for (int s = 0; s < 8; s++) begin
         rd(9'h08C + 9'(32 * s), 16'h0000);
         ldi[s] = 1 + lfsr[1:0];
         wr(9'h08C + 9'(32 * s), 2'b11, {reg_rdata_o[15:8], 8'(ldi[s])});
      end
      wr(9'h08C, 2'b00, 16'h0055);
      for (int s = 0; s < 8; s++)
         rd(9'h08C + 9'(32 * s), 16'(ldi[s]));
      run_i = 8'hFF;
      repeat (300) tick;
      run_i = 8'h00;
      repeat (3) tick;
      run_i = 8'h0F;
      repeat (100) tick;
      run_i = 8'h00;
      repeat (3) tick;
      // Reset after every stream has stopped must clear the stream 0 and 7 index registers and restart walker 0
      nrst_i = 1'b0;
      for (int s = 0; s < 8; s++)
         ldi[s] = 0;
      repeat (2) tick;
      nrst_i = 1'b1;
      rd(9'h08C, 16'h0000);
      rd(9'h16C, 16'h0000);
      ldi[0] = 2;
      wr(9'h08C, 2'b01, {reg_rdata_o[15:8], 8'h02});
      run_i = 8'h01;
      repeat (40) tick;
      run_i = 8'h00;
      repeat (3) tick;
      give_verdict;
   end
endmodule
`default_nettype wire
